// File: bench/sfh_host_if_asserts.sv
// property checker for the serial flash host interface
`timescale 1ns/1ps
`include "sfh_defs.vh"
module sfh_host_if_chk (
  // clock and reset
  input wire        ref_clk,
  input wire        sys_rst,
  // serial pins
  input wire        sclk,
  input wire        cs_n,
  input wire        serial_lane_1_out,
  input wire        serial_lane_1_oe,
  input wire        serial_lane_3_oe,
  // status and commands
  input wire [15:0] status,
  input wire        cmd_start,
  input wire        paused,
  input wire        deep_pd,
  input wire        lockout
);
  logic [6:0] bcnt;   // cycles spent busy
  logic [3:0] fage;   // cycles since a sampled clock fall
  logic       sclk_q;
  // busy length and age of the last clock fall
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bcnt   <= 7'h00;
      fage   <= 4'hF;
      sclk_q <= 1'h0;
    end else begin
      sclk_q <= sclk;
      bcnt   <= status[0] ? bcnt + 7'h01 : 7'h00;
      fage   <= (sclk_q && !sclk) ? 4'h0 : fage + {3'h0, fage != 4'hF};
    end
  end
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // ***************
  // properties
  // ***************
  property p_rst_quiet;
    @(posedge ref_clk) disable iff (1'h0)
      sys_rst |-> lockout && !cmd_start && status == 16'h0000;
  endproperty
  property p_start_ok;
    cmd_start |-> status[1] && !lockout && !deep_pd;
  endproperty
  property p_start_busy;
    cmd_start |-> ##[0:2] status[0];
  endproperty
  property p_busy_len;
    $fell(status[0]) |-> bcnt == `SFH_OP_CYC;
  endproperty
  property p_wel_clr;
    $fell(status[0]) |-> ##[0:1] !status[1];
  endproperty
  property p_lock_wel;
    lockout |-> !status[1];
  endproperty
  property p_quad_nopause;
    status[9] |-> !paused;
  endproperty
  property p_pause_sel;
    $rose(paused) |-> !cs_n;
  endproperty
  property p_pause_hiz;
    paused && $past(paused) |-> !serial_lane_1_oe;
  endproperty
  property p_quad_lane;
    serial_lane_3_oe |-> status[9];
  endproperty
  property p_fall_out;
    $changed(serial_lane_1_out) && serial_lane_1_oe && $past(serial_lane_1_oe)
      |-> fage <= 4'h6;
  endproperty
  a_rst_quiet:    assert property (p_rst_quiet)
    else $error("activity while in reset");
  a_start_ok:     assert property (p_start_ok)
    else $error("command started without write permission");
  a_start_busy:   assert property (p_start_busy)
    else $error("busy not raised after command start");
  a_busy_len:     assert property (p_busy_len)
    else $error("busy length wrong");
  a_wel_clr:      assert property (p_wel_clr)
    else $error("write latch kept after operation");
  a_lock_wel:     assert property (p_lock_wel)
    else $error("write latch set during lockout");
  a_quad_nopause: assert property (p_quad_nopause)
    else $error("pause honoured with quad enable");
  a_pause_sel:    assert property (p_pause_sel)
    else $error("pause entered while deselected");
  a_pause_hiz:    assert property (p_pause_hiz)
    else $error("output driven while paused");
  a_quad_lane:    assert property (p_quad_lane)
    else $error("lane 3 driven without quad enable");
  a_fall_out:     assert property (p_fall_out)
    else $error("output changed away from a clock fall");
  c_busy:  cover property ($rose(status[0]));
  c_pause: cover property ($rose(paused));
  c_quad:  cover property ($rose(serial_lane_3_oe));
  c_dpd:   cover property ($rose(deep_pd));
endmodule
bind sfh_host_if sfh_host_if_chk chk (
  .ref_clk, .sys_rst, .sclk, .cs_n, .serial_lane_1_out, .serial_lane_1_oe,
  .serial_lane_3_oe, .status, .cmd_start, .paused, .deep_pd, .lockout
);

// File: bench/sfh_host_if_tb.sv
// self-checking bench for the serial flash host interface
`timescale 1ns/1ps
`include "sfh_defs.vh"
module sfh_host_if_tb;
  logic        ref_clk;
  logic        sys_rst;
  logic        clk_en;
  logic [7:0]  rd_data;
  logic        flt;     // changing level on undriven lanes
  logic [15:0] starts;  // started program and erase commands
  logic        q_seen;  // device drove lane 3
  logic        d_seen;  // device drove lane 0
  logic [7:0]  rx;
  int          miscompares;
  int          checks_done;
  wire  [3:0]  pin;
  wire  [3:0]  d_out;
  wire  [3:0]  d_oe;
  wire  [3:0]  h_val;
  wire  [3:0]  h_oe;
  wire         sclk;
  wire         cs_n;
  wire  [15:0] status;
  wire  [7:0]  cmd_opcode;
  wire         cmd_start;
  wire         paused;
  wire         deep_pd;
  wire         lockout;
  // wire level of each lane from both parties
  for (genvar k = 0; k < 4; k++) begin : g_ln
    assign pin[k] = d_oe[k] ? d_out[k] : (h_oe[k] ? h_val[k] : flt);
  end
  sfh_host_if uut (
    .ref_clk, .sys_rst, .clk_en, .sclk, .cs_n, .rd_data, .status,
    .cmd_opcode, .cmd_start, .paused, .deep_pd, .lockout,
    .serial_lane_0_in (pin[0]), .serial_lane_0_out (d_out[0]),
    .serial_lane_0_oe (d_oe[0]), .serial_lane_1_in (pin[1]),
    .serial_lane_1_out (d_out[1]), .serial_lane_1_oe (d_oe[1]),
    .serial_lane_2_in (pin[2]), .serial_lane_2_out (d_out[2]),
    .serial_lane_2_oe (d_oe[2]), .serial_lane_3_in (pin[3]),
    .serial_lane_3_out (d_out[3]), .serial_lane_3_oe (d_oe[3])
  );
  sfh_host_mdl host (.sclk, .cs_n, .h_val, .h_oe, .pin);
  // clock
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // note device events between checks
  always @(posedge ref_clk) begin
    flt <= ~flt;
    if (cmd_start === 1'h1) starts <= starts + 16'h0001;
    if (d_oe[3] === 1'h1) q_seen <= 1'h1;
    if (d_oe[0] === 1'h1) d_seen <= 1'h1;
  end
  // ***************
  // helpers
  // ***************
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic settle();
    repeat (8) @(posedge ref_clk);
  endtask
  // opcode then nb bits of d, msb first
  task automatic fr(input logic [7:0] op, input int nb, input logic [15:0] d);
    host.sel(1'h0);
    host.xfer(op, 8, rx);
    if (nb > 0) host.xfer(d[15:8], nb > 8 ? 8 : nb, rx);
    if (nb > 8) host.xfer(d[7:0], nb - 8, rx);
    host.desel();
    settle();
  endtask
  // opcode, then the host lets go of lanes rel for one byte
  task automatic rd(input logic [7:0] op, input logic md,
                    input logic [3:0] rel);
    host.sel(md);
    host.xfer(op, 8, rx);
    host.h_oe <= ~rel & 4'hD;
    host.xfer(8'h00, 8, rx);
    host.desel();
    host.h_oe <= 4'hD;
    settle();
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 200 && status[0] !== 1'h0; i++) @(posedge ref_clk);
  endtask
  // ***************
  // scenarios
  // ***************
  task automatic t_boot();
    cmp(status, `SFH_STATUS_RST);
    cmp(lockout, 1'h1);
    fr(`SFH_OP_WREN, 0, 16'h0000);
    cmp(status[1], 1'h0);
    for (int i = 0; i < `SFH_PUW_CYC + 100 && lockout !== 1'h0; i++)
      @(posedge ref_clk);
    cmp(lockout, 1'h0);
  endtask
  task automatic t_prog();
    fr(`SFH_OP_PP, 8, 16'h5A00);
    cmp(starts, 16'h0000);
    fr(`SFH_OP_WREN, 0, 16'h0000);
    cmp(status, 16'h0002);
    rd(`SFH_OP_RDSR1, 1'h1, 4'h0);
    cmp(rx, 8'h02);
    rd(`SFH_OP_READ, 1'h0, 4'h0);
    cmp(rx, 8'hA5);
    fr(`SFH_OP_PP, 8, 16'h5A00);
    cmp(starts, 16'h0001);
    cmp(cmd_opcode, `SFH_OP_PP);
    cmp(status[1:0], 2'h3);
    wait_idle();
    cmp(status, 16'h0000);
  endtask
  // every dual and quad read; quad lanes only with quad enable
  task automatic t_lanes(input logic qe);
    logic [7:0] qc [4] = '{`SFH_OP_QOR, `SFH_OP_QIOR,
                           `SFH_OP_QWR, `SFH_OP_QOWR};
    logic [7:0] dc [2] = '{`SFH_OP_DOR, `SFH_OP_DIOR};
    foreach (qc[i]) begin
      q_seen <= 1'h0;
      // without quad enable the protect and pause pins stay driven
      rd(qc[i], 1'h0, qe ? 4'hD : 4'h1);
      cmp(q_seen, qe);
      if (qe) cmp(rx, 8'hAA);
    end
    foreach (dc[i]) begin
      d_seen <= 1'h0;
      rd(dc[i], 1'h0, 4'h1);
      cmp(d_seen, 1'h1);
      cmp(rx, 8'hCC);
    end
  endtask
  // cut frame, then a pause entered with clock low, left with it high
  task automatic t_pause();
    host.sel(1'h0);
    host.xfer(`SFH_OP_WREN, 5, rx);
    host.desel();
    settle();
    cmp(status[1], 1'h0);
    host.sel(1'h0);
    host.xfer(`SFH_OP_WREN, 4, rx);
    host.sclk <= 1'h0;
    #24;
    host.h_val[3] <= 1'h0;
    settle();
    cmp(paused, 1'h1);
    cmp(d_oe[1], 1'h0);
    host.xfer(8'hFF, 3, rx);
    host.h_val[3] <= 1'h1;
    settle();
    cmp(paused, 1'h1);
    host.xfer(8'h60, 4, rx);  // low half of the write enable code
    host.desel();
    settle();
    cmp(status[1], 1'h1);
  endtask
  task automatic t_wrsr();
    fr(`SFH_OP_WRSR, 8, 16'h8000);
    wait_idle();
    cmp(status, 16'h0080);
    host.h_val[2] <= 1'h0;
    fr(`SFH_OP_WREN, 0, 16'h0000);
    fr(`SFH_OP_WRSR, 16, 16'h0002);
    wait_idle();
    cmp(status, 16'h0082);
    host.h_val[2] <= 1'h1;
    fr(`SFH_OP_WRSR, 16, 16'h0002);
    wait_idle();
    cmp(status, 16'h0200);
  endtask
  task automatic t_dpd();
    fr(`SFH_OP_DPD, 0, 16'h0000);
    cmp(deep_pd, 1'h1);
    fr(`SFH_OP_WREN, 0, 16'h0000);
    cmp(status[1], 1'h0);
    fr(`SFH_OP_RDPD, 0, 16'h0000);
    cmp(deep_pd, 1'h0);
  endtask
  // main sequence
  initial begin
    sys_rst = 1'h1;
    clk_en = 1'h1;
    rd_data = 8'hA5;
    flt = 1'h0;
    starts = 16'h0000;
    q_seen = 1'h0;
    d_seen = 1'h0;
    miscompares = 0;
    checks_done = 0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'h0;
    settle();
    t_boot();
    t_prog();
    t_lanes(1'h0);
    t_pause();
    t_wrsr();
    t_lanes(1'h1);
    t_dpd();
    end_of_test();
  end
  // a clean run takes about 35 us; cut a hang short well after that
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
endmodule

// File: bench/sfh_host_mdl.sv
// spi host model driving the serial pins of the flash front end
`timescale 1ns/1ps
module sfh_host_mdl (
  // pins the host drives
  output logic       sclk,
  output logic       cs_n,
  output logic [3:0] h_val,
  output logic [3:0] h_oe,
  // resolved lane levels
  input  wire  [3:0] pin
);
  logic idle;  // clock level between frames, high for mode 3
  // deselected, protect and pause pins high, lane 1 left free
  initial begin
    idle = 1'h0;
    sclk <= 1'h0;
    cs_n <= 1'h1;
    h_val <= 4'hF;
    h_oe <= 4'hD;
  end
  // select with the clock parked at the mode's idle level
  task automatic sel(input logic md);
    idle = md;
    sclk <= md;
    #30;
    cs_n <= 1'h0;
    #30;
  endtask
  // park the clock, then deselect; callers never do it mid-pause
  task automatic desel();
    sclk <= idle;
    #30;
    cs_n <= 1'h1;
    #60;
  endtask
  // n bits msb first on lane 0, lane 1 taken late in the high phase
  task automatic xfer(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sclk <= 1'h0;
      h_val[0] <= tx[i];
      #24;
      sclk <= 1'h1;
      #23;
      rx = {rx[6:0], pin[1]};
      #1;
    end
  endtask
endmodule

// File: hw/sfh_defs.vh
// constants for the serial flash host interface front end
`ifndef SFH_DEFS_VH
`define SFH_DEFS_VH
// opcodes
`define SFH_OP_WREN     8'h06
`define SFH_OP_WRDI     8'h04
`define SFH_OP_RDSR1    8'h05
`define SFH_OP_RDSR2    8'h35
`define SFH_OP_WRSR     8'h01
`define SFH_OP_PP       8'h02
`define SFH_OP_QPP      8'h32
`define SFH_OP_SE       8'h20
`define SFH_OP_BE32     8'h52
`define SFH_OP_BE64     8'hD8
`define SFH_OP_CE       8'hC7
`define SFH_OP_SUSP     8'h75
`define SFH_OP_DPD      8'hB9
`define SFH_OP_RDPD     8'hAB
`define SFH_OP_DOR      8'h3B
`define SFH_OP_DIOR     8'hBB
`define SFH_OP_QOR      8'h6B
`define SFH_OP_QIOR     8'hEB
`define SFH_OP_QWR      8'hE7
`define SFH_OP_QOWR     8'hE3
`define SFH_OP_READ     8'h03
// status bit positions
`define SFH_S_BUSY      0
`define SFH_S_WEL       1
`define SFH_S_STATUS_PROTECT_LO      7
`define SFH_S_STATUS_PROTECT_HI      8
`define SFH_S_QE        9
// reset value of the non-volatile status
`define SFH_STATUS_RST  16'h0000
// lane modes
`define SFH_LANES_1     2'h0
`define SFH_LANES_2     2'h1
`define SFH_LANES_4     2'h2
// write lockout after power-up, in microseconds, and cycle count
`define SFH_PUW_US      10
`define SFH_CLK_MHZ     200
`define SFH_PUW_CYC     (`SFH_PUW_US * `SFH_CLK_MHZ)
// internal operation length in cycles
`define SFH_OP_CYC      64
`endif

// File: hw/sfh_host_if.v
// serial flash host interface front end
`timescale 1ns/1ps
`include "sfh_defs.vh"
module sfh_host_if (
  // clock and reset
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  // serial pins
  input  wire        sclk,
  input  wire        cs_n,
  input  wire        serial_lane_0_in,
  output reg         serial_lane_0_out,
  output reg         serial_lane_0_oe,
  input  wire        serial_lane_1_in,
  output reg         serial_lane_1_out,
  output reg         serial_lane_1_oe,
  input  wire        serial_lane_2_in,
  output reg         serial_lane_2_out,
  output reg         serial_lane_2_oe,
  input  wire        serial_lane_3_in,
  output reg         serial_lane_3_out,
  output reg         serial_lane_3_oe,
  // read data from the array side
  input  wire [7:0]  rd_data,
  // status and commands to the array side
  output reg  [15:0] status,
  output reg  [7:0]  cmd_opcode,
  output reg         cmd_start,
  output reg         paused,
  output reg         deep_pd,
  output reg         lockout
);
  // ****************************************************
  // input synchronisers
  // ****************************************************
  wire sck, sck_rise, sck_fall;
  wire csn, csn_rise, csn_fall;
  wire l0, l1, l2, l3;
  wire l3_rise, l3_fall;

  sfh_sync u_sck (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .din(sclk), .dout(sck), .rise(sck_rise), .fall(sck_fall));
  sfh_sync #(.RST_VAL(1'b1)) u_cs (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .clk_en(clk_en), .din(cs_n), .dout(csn), .rise(csn_rise), .fall(csn_fall));
  sfh_sync u_l0 (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .din(serial_lane_0_in), .dout(l0), .rise(), .fall());
  sfh_sync u_l1 (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .din(serial_lane_1_in), .dout(l1), .rise(), .fall());
  sfh_sync u_l2 (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .din(serial_lane_2_in), .dout(l2), .rise(), .fall());
  sfh_sync u_l3 (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .din(serial_lane_3_in), .dout(l3), .rise(l3_rise), .fall(l3_fall));

  // ****************************************************
  // opcode classes
  // ****************************************************
  reg  [7:0] shreg;
  wire [7:0] op_now;
  wire       d_prog;
  wire       d_wrsr;
  wire       d_wren;
  wire [1:0] d_lanes;
  wire       d_read;

  sfh_opdec u_dec (.opcode(op_now), .is_prog(d_prog), .is_wrsr(d_wrsr),
    .is_wren(d_wren), .lanes(d_lanes), .is_read(d_read));

  // ****************************************************
  // state
  // ****************************************************
  localparam [2:0] ST_OPC  = 3'b001;
  localparam [2:0] ST_DATA = 3'b010;
  localparam [2:0] ST_IGN  = 3'b100;

  reg  [2:0]  state;
  reg  [3:0]  bitcnt;
  reg  [7:0]  op;
  reg  [1:0]  lanes;
  reg  [7:0]  obyte;
  reg  [15:0] wbuf;
  reg  [4:0]  wcnt;
  reg         pause_req;
  reg         pend_write;
  reg         pend_wrsr;
  reg         is_rd;
  reg  [31:0] puw_cnt;
  reg  [6:0]  op_cnt;

  wire qe      = status[`SFH_S_QE];
  wire busy    = status[`SFH_S_BUSY];
  wire write_enable_latch     = status[`SFH_S_WEL];
  wire selected = ~csn;
  // serial events count only when selected and not paused
  wire act_rise = sck_rise & selected & ~paused;
  wire act_fall = sck_fall & selected & ~paused;
  wire [2:0] step = (lanes == `SFH_LANES_4) ? 3'h4 :
                    (lanes == `SFH_LANES_2) ? 3'h2 : 3'h1;

  assign op_now = {shreg[6:0], l0};
  wire [7:0] ob_op = (state == ST_OPC) ? op_now : op;  // new opcode at bit 8

  // status writes allowed by protect bits and write-protect pin
  function sr_writable;
    input [15:0] st;
    input        wp;
    input        quad;
    begin
      case ({st[`SFH_S_STATUS_PROTECT_HI], st[`SFH_S_STATUS_PROTECT_LO]})
        2'b00:   sr_writable = 1'b1;
        2'b01:   sr_writable = quad | wp;
        default: sr_writable = 1'b0;
      endcase
    end
  endfunction

  // decide whether an opcode may start
  function op_allowed;
    input [7:0]  o;
    input        bsy;
    input        dpd;
    input        lck;
    input        wl;
    input        prg;
    input        wsr;
    input        wen;
    input [1:0]  ln;
    input        quad;
    begin
      if (dpd)
        op_allowed = (o == `SFH_OP_RDPD);
      else if (bsy)
        op_allowed = (o == `SFH_OP_RDSR1) |
                     (o == `SFH_OP_RDSR2) |
                     (o == `SFH_OP_SUSP);
      else if (lck & (prg | wsr | wen))
        op_allowed = 1'b0;
      else if ((prg | wsr) & ~wl)
        op_allowed = 1'b0;
      else if ((ln == `SFH_LANES_4) & ~quad)
        op_allowed = 1'b0;
      else
        op_allowed = 1'b1;
    end
  endfunction

  // ****************************************************
  // power-up lockout timer
  // ****************************************************
  // sys_rst is the supply-threshold detector
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      puw_cnt <= 32'h0000_0000;
      lockout <= 1'b1;
    end else if (clk_en) begin
      if (puw_cnt == `SFH_PUW_CYC - 1)
        lockout <= 1'b0;
      else
        puw_cnt <= puw_cnt + 32'h0000_0001;
    end
  end

  // ****************************************************
  // pause control
  // ****************************************************
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      paused    <= 1'b0;
      pause_req <= 1'b0;
    end else if (clk_en) begin
      if (csn | qe | (lanes == `SFH_LANES_4)) begin
        paused    <= 1'b0;
        pause_req <= 1'b0;
      end else if (~paused) begin
        if (l3_fall & ~sck)
          paused <= 1'b1;
        else if (l3_fall)
          pause_req <= 1'b1;
        else if (pause_req & sck_fall) begin
          paused    <= ~l3;
          pause_req <= 1'b0;
        end
      end else begin
        if (l3_rise & ~sck)
          paused <= 1'b0;
        else if (l3_rise)
          pause_req <= 1'b1;
        else if (pause_req & sck_fall) begin
          paused    <= ~l3;
          pause_req <= 1'b0;
        end
      end
    end
  end

  // ****************************************************
  // instruction engine
  // ****************************************************
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= ST_OPC;
      bitcnt     <= 4'h0;
      shreg      <= 8'h00;
      op         <= 8'h00;
      lanes      <= `SFH_LANES_1;
      wbuf       <= 16'h0000;
      wcnt       <= 5'h00;
      pend_write <= 1'b0;
      pend_wrsr  <= 1'b0;
      is_rd      <= 1'b0;
      status     <= `SFH_STATUS_RST;
      deep_pd    <= 1'b0;
      cmd_opcode <= 8'h00;
      cmd_start  <= 1'b0;
      op_cnt     <= 7'h00;
    end else if (clk_en) begin
      cmd_start <= 1'b0;
      // internal operation running
      if (busy) begin
        if (op_cnt == `SFH_OP_CYC - 1) begin
          status[`SFH_S_BUSY] <= 1'b0;
          status[`SFH_S_WEL]  <= 1'b0;
          op_cnt <= 7'h00;
        end else
          op_cnt <= op_cnt + 7'h01;
      end
      // select low at any clock level starts a frame
      if (csn_fall) begin
        state  <= ST_OPC;
        bitcnt <= 4'h0;
        lanes  <= `SFH_LANES_1;
      end else if (csn_rise) begin
        // frame end commits a writable status write of 8 or more bits or any accepted program, else aborts
        if (pend_wrsr & (wcnt >= 5'h08) &
            sr_writable(status, l2, qe)) begin
          status[15:2] <= wcnt[4] ? {wbuf[7:0], wbuf[15:10]} :
                                    {status[15:8], wbuf[7:2]};
          status[`SFH_S_BUSY] <= 1'b1;
          op_cnt <= 7'h00;
        end else if (pend_write) begin
          status[`SFH_S_BUSY] <= 1'b1;
          op_cnt     <= 7'h00;
          cmd_opcode <= op;
          cmd_start  <= 1'b1;
        end
        pend_write <= 1'b0;
        pend_wrsr  <= 1'b0;
        state      <= ST_OPC;
        bitcnt     <= 4'h0;
        lanes      <= `SFH_LANES_1;
      end else if (act_rise) begin
        case (state)
          ST_OPC: begin
            shreg <= op_now;
            if (bitcnt == 4'h7) begin
              op <= op_now;
              if (op_allowed(op_now, busy, deep_pd, lockout, write_enable_latch, d_prog,
                             d_wrsr, d_wren, d_lanes, qe)) begin
                state <= ST_DATA;
                lanes <= d_lanes;
                if (d_wren)
                  status[`SFH_S_WEL] <= 1'b1;
                if (op_now == `SFH_OP_WRDI)
                  status[`SFH_S_WEL] <= 1'b0;
                if (op_now == `SFH_OP_DPD)
                  deep_pd <= 1'b1;
                if (op_now == `SFH_OP_RDPD)
                  deep_pd <= 1'b0;
                pend_write <= d_prog;
                pend_wrsr  <= d_wrsr;
                is_rd      <= d_read;
                wcnt       <= 5'h00;
              end else
                state <= ST_IGN;
            end
            bitcnt <= bitcnt + 4'h1;
          end
          ST_DATA: begin
            if (pend_wrsr & ~wcnt[4]) begin
              wbuf <= {wbuf[14:0], l0};
              wcnt <= wcnt + 5'h01;
            end
          end
          ST_IGN:  state <= ST_IGN;
          default: state <= ST_OPC;
        endcase
      end
    end
  end

  // ****************************************************
  // output shifter
  // ****************************************************
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      obyte             <= 8'h00;
      serial_lane_0_out <= 1'b0;
      serial_lane_1_out <= 1'b0;
      serial_lane_2_out <= 1'b0;
      serial_lane_3_out <= 1'b0;
      serial_lane_0_oe  <= 1'b0;
      serial_lane_1_oe  <= 1'b0;
      serial_lane_2_oe  <= 1'b0;
      serial_lane_3_oe  <= 1'b0;
    end else if (clk_en) begin
      if (csn | (state != ST_DATA) | ~is_rd) begin
        {serial_lane_3_oe, serial_lane_2_oe,
         serial_lane_1_oe, serial_lane_0_oe} <= 4'h0;
        obyte <= (ob_op == `SFH_OP_RDSR2) ? status[15:8] :
                 (ob_op == `SFH_OP_RDSR1) ? status[7:0] : rd_data;
      end else if (paused) begin
        {serial_lane_3_oe, serial_lane_2_oe,
         serial_lane_1_oe, serial_lane_0_oe} <= 4'h0;
      end else if (act_fall) begin
        // shift out on the falling edge
        case (lanes)
          `SFH_LANES_4: begin
            {serial_lane_3_out, serial_lane_2_out,
             serial_lane_1_out, serial_lane_0_out} <= obyte[7:4];
            serial_lane_0_oe <= 1'b1;
            serial_lane_1_oe <= 1'b1;
            serial_lane_2_oe <= 1'b1;
            serial_lane_3_oe <= 1'b1;
          end
          `SFH_LANES_2: begin
            {serial_lane_1_out, serial_lane_0_out} <= obyte[7:6];
            serial_lane_0_oe <= 1'b1;
            serial_lane_1_oe <= 1'b1;
          end
          default: begin
            serial_lane_1_out <= obyte[7];
            serial_lane_1_oe  <= 1'b1;
          end
        endcase
        obyte <= (step == 3'h1) ? {obyte[6:0], obyte[7]} :
                 (step == 3'h2) ? {obyte[5:0], obyte[7:6]} :
                                  {obyte[3:0], obyte[7:4]};
      end
    end
  end
endmodule

// File: hw/sfh_opdec.v
// opcode classifier for the instruction filter
`timescale 1ns/1ps
`include "sfh_defs.vh"
module sfh_opdec (
  // opcode in
  input  wire [7:0] opcode,
  // classes out
  output reg        is_prog,
  output reg        is_wrsr,
  output reg        is_wren,
  output reg  [1:0] lanes,
  output reg        is_read
);
  // class each opcode once
  always @* begin
    is_prog = 1'b0;
    is_wrsr = 1'b0;
    is_wren = 1'b0;
    is_read = 1'b0;
    lanes   = `SFH_LANES_1;
    case (opcode)
      `SFH_OP_PP, `SFH_OP_QPP, `SFH_OP_SE, `SFH_OP_BE32,
      `SFH_OP_BE64, `SFH_OP_CE: is_prog = 1'b1;
      `SFH_OP_WRSR: is_wrsr = 1'b1;
      `SFH_OP_WREN: is_wren = 1'b1;
      `SFH_OP_RDSR1, `SFH_OP_RDSR2, `SFH_OP_READ: is_read = 1'b1;
      `SFH_OP_DOR, `SFH_OP_DIOR: begin
        is_read = 1'b1;
        lanes   = `SFH_LANES_2;
      end
      `SFH_OP_QOR, `SFH_OP_QIOR, `SFH_OP_QWR, `SFH_OP_QOWR: begin
        is_read = 1'b1;
        lanes   = `SFH_LANES_4;
      end
      default: lanes = `SFH_LANES_1;
    endcase
  end
endmodule

// File: hw/sfh_sync.v
// two-flop synchroniser with edge flags for the sampled signal
`timescale 1ns/1ps
module sfh_sync #(
  // level held through reset, the idle level of the pin
  parameter [0:0] RST_VAL = 1'b0
) (
  // clock and reset
  input  wire ref_clk,
  input  wire sys_rst,
  input  wire clk_en,
  // asynchronous input
  input  wire din,
  // synchronised level and edges
  output wire dout,
  output wire rise,
  output wire fall
);
  reg s1;
  reg s2;
  reg s3;

  // first flop feeds only the second
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
    end else if (clk_en) begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign dout = s2;
  assign rise = s2 & ~s3;
  assign fall = ~s2 & s3;
endmodule
